// ==== core/fcs_pkg.sv ====
// Shared constants and types of the flash command sequencer
package fcs_pkg;

  // ==========================================================
  // Command word layout
  localparam int KEY_MSB = 31;
  localparam int KEY_LSB = 24;
  localparam int ARG_MSB = 23;
  localparam int ARG_LSB = 8;
  localparam int CODE_MSB = 7;
  localparam int GRP_MSB = 15;
  localparam int GRP_LSB = 2;
  localparam int GRP_SEL_MSB = 1;

  // ==========================================================
  // Command codes
  localparam logic [7:0] descriptor_read_cmd = 8'h00;
  localparam logic [7:0] page_program_cmd = 8'h01;
  localparam logic [7:0] program_lock_cmd = 8'h02;
  localparam logic [7:0] erase_program_cmd = 8'h03;
  localparam logic [7:0] erase_program_lock_cmd = 8'h04;
  localparam logic [7:0] full_plane_erase_cmd = 8'h05;
  localparam logic [7:0] code_gap = 8'h06;
  localparam logic [7:0] page_group_erase_cmd = 8'h07;
  localparam logic [7:0] set_region_lock_cmd = 8'h08;
  localparam logic [7:0] clear_region_lock_cmd = 8'h09;
  localparam logic [7:0] read_region_lock_cmd = 8'h0A;
  localparam logic [7:0] set_nvbit_cmd = 8'h0B;
  localparam logic [7:0] clear_nvbit_cmd = 8'h0C;
  localparam logic [7:0] read_nvbit_cmd = 8'h0D;
  localparam logic [7:0] id_read_begin_cmd = 8'h0E;
  localparam logic [7:0] id_read_end_cmd = 8'h0F;
  localparam logic [7:0] calibration_read_cmd = 8'h10;
  localparam logic [7:0] sector_wipe_cmd = 8'h11;
  localparam logic [7:0] signature_write_cmd = 8'h12;
  localparam logic [7:0] signature_wipe_cmd = 8'h13;
  localparam logic [7:0] signature_read_begin_cmd = 8'h14;
  localparam logic [7:0] signature_read_end_cmd = 8'h15;

  // ==========================================================
  // Descriptor and result layout
  localparam int DESC_IDX_ID = 0;
  localparam int DESC_IDX_SIZE = 1;
  localparam int DESC_IDX_PAGE = 2;
  localparam int DESC_IDX_NPLANE = 3;
  localparam int DESC_IDX_PLANE = 4;
  localparam int PLANE_COUNT = 1;
  localparam int BYTES_PER_WORD = 4;
  localparam int WORD_BITS = 32;
  localparam int WORD_LSB = 2;
  localparam int EPA_BASE_PAGES = 4;
  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

  typedef enum logic [2:0] {
    RES_NONE = 3'b000,
    RES_DESC = 3'b001,
    RES_LOCK = 3'b011,
    RES_NV = 3'b010,
    RES_CAL = 3'b110
  } fcs_res_type;

  typedef enum logic [2:0] {
    OP_ERASE = 3'b000,
    OP_PROG = 3'b001,
    OP_SIG_ERASE = 3'b010,
    OP_SIG_PROG = 3'b011
  } fcs_op_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHECK = 3'b001,
    ST_ERASE = 3'b011,
    ST_PROG = 3'b010,
    ST_PDONE = 3'b110,
    ST_FINISH = 3'b111,
    ST_ID = 3'b101
  } fcs_st_type;

endpackage

// ==== core/fcs_latch_if.sv ====
// Read and clear path between sequencer and page latch buffer
`timescale 1ns/1ns
interface fcs_latch_if #(parameter int IDX_W = 7);
  logic [IDX_W-1:0] rd_idx;
  logic [31:0] rd_data;
  logic clr;
  modport seq (output rd_idx, output clr, input rd_data);
  modport lat (input rd_idx, input clr, output rd_data);
endinterface

// ==== core/fcs_latch_buf.sv ====
// Word-only page latch buffer with wait-stated write completion
`timescale 1ns/1ns
module fcs_latch_buf
  import fcs_pkg::*;
#(
  parameter int PAGE_WORDS = 128,
  parameter int ADDR_W = 20,
  parameter int FWS_W = 4
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wr,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [FWS_W-1:0] fws,
  output logic wr_ack,
  fcs_latch_if.lat lat
);
  localparam int IDX_W = $clog2(PAGE_WORDS);

  typedef struct packed {
    logic [PAGE_WORDS-1:0] filled;
    logic busy;
    logic [FWS_W-1:0] cnt;
  } fcs_lat_type;

  fcs_lat_type r;
  fcs_lat_type n;
  logic [31:0] mem [PAGE_WORDS];
  logic accept;
  logic [IDX_W-1:0] widx;

  // ==========================================================
  // Write acceptance and wait states
  assign accept = wr && !r.busy;
  assign widx = wr_addr[WORD_LSB +: IDX_W];
  assign wr_ack = r.busy && (r.cnt == fws);
  // Unwritten words read as erased
  assign lat.rd_data = r.filled[lat.rd_idx] ? mem[lat.rd_idx] : ERASED_WORD;

  always_comb
  begin
    n = r;
    if (wr_ack)
    begin
      n.busy = 1'b0;
    end
    else if (r.busy)
    begin
      n.cnt = r.cnt + 1'b1;
    end
    if (lat.clr)
    begin
      n.filled = '0;
    end
    if (accept)
    begin
      n.busy = 1'b1;
      n.cnt = '0;
      n.filled[widx] = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (accept)
    begin
      mem[widx] <= wr_data;
    end
  end

endmodule

// ==== core/fcs_sequencer.sv ====
// Flash command sequencer: keyed commands, lock protection, results
`timescale 1ns/1ns
module fcs_sequencer
  import fcs_pkg::*;
#(
  parameter int PAGE_WORDS = 128,
  parameter int NUM_PAGES = 2048,
  parameter int NUM_LOCK = 64,
  parameter int PAGES_PER_SECTOR = 128,
  parameter int NV_BITS = 8,
  parameter int ADDR_W = 20,
  parameter int FWS_W = 4,
  parameter logic [7:0] CMD_KEY = 8'hA5,
  // Arbitrary value
  parameter logic [31:0] FLASH_ID = 32'h0000_0001,
  parameter logic [31:0] CALIB = 32'h0000_0000
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cmd_wr,
  input wire logic [31:0] cmd_data,
  input wire logic status_rd,
  input wire logic result_rd,
  input wire logic ready_irq_en,
  input wire logic [FWS_W-1:0] fws,
  input wire logic latch_wr,
  input wire logic [ADDR_W-1:0] latch_addr,
  input wire logic [31:0] latch_data,
  output logic latch_ack,
  output logic op_done_flag,
  output logic bad_command_flag,
  output logic locked_region_error_flag,
  output logic flash_error_flag,
  output logic ready_irq,
  output logic [31:0] result_value_field,
  output logic [NV_BITS-1:0] general_nonvolatile_bits,
  output logic [NUM_LOCK-1:0] region_lock_bits,
  output logic id_read_mode,
  output logic sig_read_mode,
  output logic arr_req,
  output logic [2:0] arr_op,
  output logic [15:0] arr_page,
  output logic [16:0] arr_count,
  output logic [6:0] arr_word,
  output logic [31:0] arr_wdata,
  input wire logic arr_ack,
  input wire logic arr_verify_fail
);
  localparam int IDX_W = $clog2(PAGE_WORDS);
  localparam int PPR = NUM_PAGES / NUM_LOCK;
  localparam int PAGE_BYTES = PAGE_WORDS * BYTES_PER_WORD;
  localparam int FLASH_BYTES = NUM_PAGES * PAGE_BYTES;
  localparam int DESC_IDX_NLOCK = DESC_IDX_PLANE + PLANE_COUNT;
  localparam int DESC_LEN = DESC_IDX_NLOCK + 1 + NUM_LOCK;
  localparam int LOCK_WORDS = (NUM_LOCK + WORD_BITS - 1) / WORD_BITS;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(PAGE_WORDS - 1);

  typedef struct packed {
    fcs_st_type state;
    logic ready;
    logic bad_cmd;
    logic lock_err;
    logic flash_err;
    logic id_mode;
    logic sig_mode;
    logic [7:0] cmd;
    logic [15:0] arg;
    logic [IDX_W-1:0] idx;
    fcs_res_type res_kind;
    logic [7:0] res_idx;
    logic [31:0] result;
    logic [NUM_LOCK-1:0] locks;
    logic [NV_BITS-1:0] nvbits;
    logic req;
    fcs_op_type op;
    logic [15:0] page;
    logic [16:0] count;
    logic [31:0] wdata;
  } fcs_state_type;

  fcs_state_type r;
  fcs_state_type n;
  fcs_latch_if #(.IDX_W(IDX_W)) lif ();

  // ==========================================================
  // Helper functions
  function automatic logic code_valid(input logic [7:0] c);
    return (c <= signature_read_end_cmd) && (c != code_gap);
  endfunction

  function automatic logic range_locked(input int first, input int cnt, input logic [NUM_LOCK-1:0] lk);
    logic hit;
    hit = 1'b0;
    for (int g = 0; g < NUM_LOCK; g++)
    begin
      if (lk[g] && (first < (g + 1) * PPR) && (first + cnt > g * PPR))
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [31:0] res_word(input fcs_res_type k, input logic [7:0] i,
                                           input logic [NUM_LOCK-1:0] lk, input logic [NV_BITS-1:0] nv);
    logic [31:0] w;
    int x;
    w = '0;
    x = int'(i);
    case (k)
      RES_DESC:
      begin
        if (x == DESC_IDX_ID)
          w = FLASH_ID;
        else if (x == DESC_IDX_SIZE)
          w = 32'(FLASH_BYTES);
        else if (x == DESC_IDX_PAGE)
          w = 32'(PAGE_BYTES);
        else if (x == DESC_IDX_NPLANE)
          w = 32'(PLANE_COUNT);
        else if (x < DESC_IDX_NLOCK)
          w = 32'(FLASH_BYTES / PLANE_COUNT);
        else if (x == DESC_IDX_NLOCK)
          w = 32'(NUM_LOCK);
        else if (x < DESC_LEN)
          w = 32'(PPR * PAGE_BYTES);
      end
      RES_LOCK:
      begin
        if (x < LOCK_WORDS)
        begin
          for (int b = 0; b < WORD_BITS; b++)
          begin
            if (x * WORD_BITS + b < NUM_LOCK)
            begin
              w[b] = lk[x * WORD_BITS + b];
            end
          end
        end
      end
      RES_NV:
      begin
        if (x == 0)
          w[NV_BITS-1:0] = nv;
      end
      RES_CAL:
      begin
        if (x == 0)
          w = CALIB;
      end
      default:
      begin
        w = '0;
      end
    endcase
    return w;
  endfunction

  // ==========================================================
  // Page latch buffer
  fcs_latch_buf #(
    .PAGE_WORDS(PAGE_WORDS),
    .ADDR_W(ADDR_W),
    .FWS_W(FWS_W)
  ) u_latch (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr(latch_wr),
    .wr_addr(latch_addr),
    .wr_data(latch_data),
    .fws(fws),
    .wr_ack(latch_ack),
    .lat(lif.lat)
  );

  assign lif.rd_idx = r.idx;
  assign lif.clr = (r.state == ST_PDONE);

  // ==========================================================
  // Command state machine
  always_comb
  begin
    int first;
    int cnt;
    logic is_erase;
    logic is_prog;
    int reg_i;
    first = 0;
    cnt = 1;
    is_erase = 1'b0;
    is_prog = 1'b0;
    reg_i = int'(r.arg) / PPR;
    n = r;
    // Status read clears errors; later sets in this cycle win
    if (status_rd)
    begin
      n.bad_cmd = 1'b0;
      n.lock_err = 1'b0;
      n.flash_err = 1'b0;
    end
    if (result_rd && r.ready && (r.res_idx != '1))
    begin
      n.res_idx = r.res_idx + 1'b1;
    end
    case (r.state)
      ST_IDLE, ST_ID:
      begin
        if (cmd_wr)
        begin
          n.ready = 1'b0;
          n.res_kind = RES_NONE;
          n.res_idx = '0;
          n.id_mode = 1'b0;
          if ((cmd_data[KEY_MSB:KEY_LSB] != CMD_KEY) || !code_valid(cmd_data[CODE_MSB:0]))
          begin
            n.bad_cmd = 1'b1;
            n.state = ST_FINISH;
          end
          else
          begin
            n.cmd = cmd_data[CODE_MSB:0];
            n.arg = cmd_data[ARG_MSB:ARG_LSB];
            n.state = ST_CHECK;
          end
        end
      end
      ST_CHECK:
      begin
        n.state = ST_FINISH;
        case (r.cmd)
          page_program_cmd, program_lock_cmd:
          begin
            first = int'(r.arg);
            is_prog = 1'b1;
          end
          erase_program_cmd, erase_program_lock_cmd:
          begin
            first = int'(r.arg);
            is_erase = 1'b1;
          end
          full_plane_erase_cmd:
          begin
            cnt = NUM_PAGES;
            is_erase = 1'b1;
          end
          page_group_erase_cmd:
          begin
            first = int'(r.arg[GRP_MSB:GRP_LSB]);
            cnt = EPA_BASE_PAGES << r.arg[GRP_SEL_MSB:0];
            is_erase = 1'b1;
          end
          sector_wipe_cmd:
          begin
            first = int'(r.arg) - (int'(r.arg) % PAGES_PER_SECTOR);
            cnt = PAGES_PER_SECTOR;
            is_erase = 1'b1;
          end
          set_region_lock_cmd, clear_region_lock_cmd:
          begin
            if (reg_i < NUM_LOCK)
            begin
              n.locks[reg_i] = (r.cmd == set_region_lock_cmd);
            end
          end
          set_nvbit_cmd, clear_nvbit_cmd:
          begin
            if (int'(r.arg) < NV_BITS)
            begin
              n.nvbits[int'(r.arg)] = (r.cmd == set_nvbit_cmd);
            end
          end
          descriptor_read_cmd:
            n.res_kind = RES_DESC;
          read_region_lock_cmd:
            n.res_kind = RES_LOCK;
          read_nvbit_cmd:
            n.res_kind = RES_NV;
          calibration_read_cmd:
            n.res_kind = RES_CAL;
          id_read_begin_cmd:
          begin
            n.id_mode = 1'b1;
            n.state = ST_ID;
          end
          signature_write_cmd:
          begin
            n.idx = '0;
            n.op = OP_SIG_PROG;
            n.page = '0;
            n.state = ST_PROG;
          end
          signature_wipe_cmd:
          begin
            n.op = OP_SIG_ERASE;
            n.page = '0;
            n.count = 17'(1);
            n.req = 1'b1;
            n.state = ST_ERASE;
          end
          signature_read_begin_cmd:
            n.sig_mode = 1'b1;
          signature_read_end_cmd:
            n.sig_mode = 1'b0;
          default:
            n.state = ST_FINISH;
        endcase
        if ((is_erase || is_prog) && range_locked(first, cnt, r.locks))
        begin
          n.lock_err = 1'b1;
        end
        else if (is_erase)
        begin
          n.op = OP_ERASE;
          n.page = 16'(first);
          n.count = 17'(cnt);
          n.req = 1'b1;
          n.state = ST_ERASE;
        end
        else if (is_prog)
        begin
          n.op = OP_PROG;
          n.page = 16'(first);
          n.idx = '0;
          n.state = ST_PROG;
        end
      end
      ST_ERASE:
      begin
        if (arr_ack)
        begin
          n.req = 1'b0;
          if (arr_verify_fail)
          begin
            n.flash_err = 1'b1;
          end
          if ((r.cmd == erase_program_cmd) || (r.cmd == erase_program_lock_cmd))
          begin
            n.op = OP_PROG;
            n.idx = '0;
            n.state = ST_PROG;
          end
          else
          begin
            n.state = ST_FINISH;
          end
        end
      end
      ST_PROG:
      begin
        if (!r.req)
        begin
          // Erased latch words need no array write
          if (lif.rd_data == ERASED_WORD)
          begin
            if (r.idx == LAST_IDX)
              n.state = ST_PDONE;
            else
              n.idx = r.idx + 1'b1;
          end
          else
          begin
            n.wdata = lif.rd_data;
            n.req = 1'b1;
          end
        end
        else if (arr_ack)
        begin
          n.req = 1'b0;
          if (arr_verify_fail)
          begin
            n.flash_err = 1'b1;
          end
          if (r.idx == LAST_IDX)
            n.state = ST_PDONE;
          else
            n.idx = r.idx + 1'b1;
        end
      end
      ST_PDONE:
      begin
        if (((r.cmd == program_lock_cmd) || (r.cmd == erase_program_lock_cmd)) && (reg_i < NUM_LOCK))
        begin
          n.locks[reg_i] = 1'b1;
        end
        n.state = ST_FINISH;
      end
      ST_FINISH:
      begin
        n.ready = 1'b1;
        n.state = ST_IDLE;
      end
      default:
      begin
        n.state = ST_IDLE;
      end
    endcase
    n.result = res_word(n.res_kind, n.res_idx, n.locks, n.nvbits);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      r <= '0;
      r.state <= ST_IDLE;
      r.ready <= 1'b1;
      r.res_kind <= RES_NONE;
      r.op <= OP_ERASE;
    end
    else
    begin
      r <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign op_done_flag = r.ready;
  assign ready_irq = r.ready && ready_irq_en;
  assign bad_command_flag = r.bad_cmd;
  assign locked_region_error_flag = r.lock_err;
  assign flash_error_flag = r.flash_err;
  assign result_value_field = r.result;
  assign general_nonvolatile_bits = r.nvbits;
  assign region_lock_bits = r.locks;
  assign id_read_mode = r.id_mode;
  assign sig_read_mode = r.sig_mode;
  assign arr_req = r.req;
  assign arr_op = r.op;
  assign arr_page = r.page;
  assign arr_count = r.count;
  assign arr_word = 7'(r.idx);
  assign arr_wdata = r.wdata;

endmodule

// ==== sim/fcs_sequencer_sva.sv ====
// Port assertions for the flash command sequencer
`timescale 1ns/1ns
module fcs_sequencer_sva
  import fcs_pkg::*;
#(
  parameter int FWS_W = 4,
  parameter logic [7:0] CMD_KEY = 8'hA5
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cmd_wr,
  input wire logic [31:0] cmd_data,
  input wire logic status_rd,
  input wire logic ready_irq_en,
  input wire logic [FWS_W-1:0] fws,
  input wire logic latch_wr,
  input wire logic latch_ack,
  input wire logic op_done_flag,
  input wire logic bad_command_flag,
  input wire logic locked_region_error_flag,
  input wire logic flash_error_flag,
  input wire logic ready_irq,
  input wire logic [31:0] result_value_field,
  input wire logic id_read_mode,
  input wire logic arr_req,
  input wire logic [15:0] arr_page,
  input wire logic [6:0] arr_word,
  input wire logic arr_ack,
  input wire logic arr_verify_fail
);
  logic [7:0] wait_r;
  logic [7:0] wait_nxt;
  logic take;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  assign take = cmd_wr && op_done_flag;
  // Cycles a latch write has waited
  always_comb wait_nxt = (latch_wr && !latch_ack) ? wait_r + 8'h01 : 8'h00;
  always_ff @(posedge mclk) wait_r <= rst_b ? wait_nxt : 8'h00;
  chk_cmd_clears_ready: assert property (take |=> !op_done_flag && result_value_field == 32'h0000_0000)
    else $error("ready or result not cleared by command write");
  chk_irq_follows_ready: assert property (ready_irq == (op_done_flag && ready_irq_en))
    else $error("ready interrupt does not follow ready and enable");
  chk_id_mode_busy: assert property (id_read_mode |-> !op_done_flag)
    else $error("ready set in id read mode");
  chk_bad_key_flag: assert property (take && cmd_data[31:24] != CMD_KEY |-> ##3 bad_command_flag && op_done_flag)
    else $error("bad keyword not flagged");
  chk_bad_flag_clear: assert property (bad_command_flag && status_rd && !take |=> !bad_command_flag)
    else $error("command error not cleared by status read");
  chk_lock_err_idle: assert property ($rose(locked_region_error_flag) |-> !arr_req ##1 op_done_flag)
    else $error("locked target touched the array");
  chk_arr_req_hold: assert property (arr_req && !arr_ack |=> arr_req && $stable(arr_page) && $stable(arr_word))
    else $error("array request changed before acknowledge");
  chk_verify_fail_flag: assert property (arr_ack && arr_verify_fail |-> ##[1:3] flash_error_flag)
    else $error("failed verify not flagged");
  chk_latch_wait: assert property (latch_ack |-> wait_r == 8'(fws) + 8'h01)
    else $error("latch write wait states wrong");
  chk_reset_state: assert property ($rose(rst_b) |-> op_done_flag && !bad_command_flag && !flash_error_flag)
    else $error("wrong flags after reset");
endmodule
bind fcs_sequencer fcs_sequencer_sva #(.FWS_W(FWS_W), .CMD_KEY(CMD_KEY)) u_sva (.mclk(mclk), .rst_b(rst_b),
  .cmd_wr(cmd_wr), .cmd_data(cmd_data), .status_rd(status_rd), .ready_irq_en(ready_irq_en), .fws(fws),
  .latch_wr(latch_wr), .latch_ack(latch_ack), .op_done_flag(op_done_flag), .bad_command_flag(bad_command_flag),
  .locked_region_error_flag(locked_region_error_flag), .flash_error_flag(flash_error_flag), .ready_irq(ready_irq),
  .result_value_field(result_value_field), .id_read_mode(id_read_mode), .arr_req(arr_req), .arr_page(arr_page),
  .arr_word(arr_word), .arr_ack(arr_ack), .arr_verify_fail(arr_verify_fail));

// ==== sim/fcs_flash_model.sv ====
// Behavioural flash array answering the sequencer's requests
`timescale 1ns/1ns
module fcs_flash_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic arr_req,
  input wire logic [2:0] arr_op,
  input wire logic [15:0] arr_page,
  input wire logic [16:0] arr_count,
  input wire logic [6:0] arr_word,
  input wire logic [31:0] arr_wdata,
  input wire logic slow,
  input wire logic fail_next,
  output logic arr_ack,
  output logic arr_verify_fail
);
  logic [31:0] mem [int];
  int cnt;
  function automatic logic [31:0] peek(input int page, input int word);
    return mem.exists(page * 128 + word) ? mem[page * 128 + word] : 32'hFFFF_FFFF;
  endfunction
  always @(posedge mclk)
  begin
    arr_ack <= 1'b0;
    // Meaningless outside an acknowledge
    arr_verify_fail <= ~arr_verify_fail;
    if (!rst_b)
    begin
      cnt <= 0;
      arr_verify_fail <= 1'b0;
    end
    else if (arr_req && !arr_ack)
    begin
      if (cnt < (slow ? 6 : 1))
        cnt <= cnt + 1;
      else
      begin
        cnt <= 0;
        arr_ack <= 1'b1;
        arr_verify_fail <= fail_next;
        if (arr_op == 3'b000)
          foreach (mem[k])
            if (k / 128 >= arr_page && k / 128 < arr_page + arr_count)
              mem[k] = 32'hFFFF_FFFF;
        if (arr_op == 3'b001)
          mem[arr_page * 128 + arr_word] = peek(arr_page, arr_word) & arr_wdata;
      end
    end
  end
endmodule

// ==== sim/fcs_sequencer_tb_top.sv ====
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ns
module fcs_sequencer_tb_top;
  import fcs_pkg::*;
  logic mclk, rst_b, cmd_wr, status_rd, result_rd, ready_irq_en, latch_wr, latch_ack, op_done_flag;
  logic bad_command_flag, locked_region_error_flag, flash_error_flag, ready_irq, id_read_mode, sig_read_mode;
  logic arr_req, arr_ack, arr_verify_fail, slow, fail_next;
  logic [3:0] fws;
  logic [19:0] latch_addr;
  logic [31:0] cmd_data, latch_data, result_value_field, arr_wdata;
  logic [7:0] nv_bits;
  logic [63:0] lock_bits;
  logic [2:0] arr_op;
  logic [15:0] arr_page;
  logic [16:0] arr_count;
  logic [6:0] arr_word;
  int error_cnt = 0;
  int checks_done = 0;
  fcs_sequencer u_dut (.mclk(mclk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_data(cmd_data), .status_rd(status_rd),
    .result_rd(result_rd), .ready_irq_en(ready_irq_en), .fws(fws), .latch_wr(latch_wr), .latch_addr(latch_addr),
    .latch_data(latch_data), .latch_ack(latch_ack), .op_done_flag(op_done_flag), .bad_command_flag(bad_command_flag),
    .locked_region_error_flag(locked_region_error_flag), .flash_error_flag(flash_error_flag), .ready_irq(ready_irq),
    .result_value_field(result_value_field), .general_nonvolatile_bits(nv_bits), .region_lock_bits(lock_bits),
    .id_read_mode(id_read_mode), .sig_read_mode(sig_read_mode), .arr_req(arr_req), .arr_op(arr_op),
    .arr_page(arr_page), .arr_count(arr_count), .arr_word(arr_word), .arr_wdata(arr_wdata), .arr_ack(arr_ack),
    .arr_verify_fail(arr_verify_fail));
  fcs_flash_model u_model (.mclk(mclk), .rst_b(rst_b), .arr_req(arr_req), .arr_op(arr_op), .arr_page(arr_page),
    .arr_count(arr_count), .arr_word(arr_word), .arr_wdata(arr_wdata), .slow(slow), .fail_next(fail_next),
    .arr_ack(arr_ack), .arr_verify_fail(arr_verify_fail));
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic pulse(input bit res);
    @(negedge mclk);
    if (res) result_rd = 1; else status_rd = 1;
    @(negedge mclk);
    result_rd = 0;
    status_rd = 0;
  endtask
  task automatic cmd(input logic [7:0] code, input logic [15:0] arg, input logic [7:0] key = 8'hA5,
                     input bit wait_rdy = 1);
    int n;
    @(negedge mclk);
    cmd_wr = 1;
    cmd_data = {key, arg, code};
    @(negedge mclk);
    cmd_wr = 0;
    cmd_data = ~cmd_data;
    check(op_done_flag, 0);
    check(result_value_field, 0);
    n = 0;
    while (wait_rdy && op_done_flag !== 1'b1 && n < 5000)
    begin
      @(negedge mclk);
      n++;
    end
    if (wait_rdy) check(op_done_flag, 1);
  endtask
  task automatic lwr(input int page, input int word, input logic [31:0] d);
    int n;
    @(negedge mclk);
    latch_wr = 1;
    latch_addr = 20'(page * 512 + word * 4);
    latch_data = d;
    n = 0;
    while (latch_ack !== 1'b1 && n < 64)
    begin
      @(negedge mclk);
      n++;
    end
    check(n, fws + 1);
    @(negedge mclk);
    latch_wr = 0;
    latch_data = ~d;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_desc;
    logic [31:0] e;
    check({op_done_flag, bad_command_flag, locked_region_error_flag, flash_error_flag}, 4'h8);
    cmd(8'h00, 16'h0000);
    for (int i = 0; i < 72; i++)
    begin
      e = i == 0 ? 32'h0000_0001 : (i == 1 || i == 4) ? 32'h0010_0000 : i == 2 ? 32'h0000_0200 :
          i == 3 ? 32'h0000_0001 : i == 5 ? 32'h0000_0040 : i < 70 ? 32'h0000_4000 : 32'h0000_0000;
      check(result_value_field, e);
      pulse(1);
    end
    $display("Descriptor test done");
  endtask
  task automatic t_codes;
    logic [7:0] codes [20] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A,
                               8'h0B, 8'h0C, 8'h0D, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
    logic [7:0] bad [3] = '{8'h06, 8'h16, 8'hFF};
    ready_irq_en = 1;
    foreach (codes[i])
    begin
      cmd(codes[i], 16'h0000);
      check(bad_command_flag, 0);
      check(ready_irq, 1);
      pulse(0);
    end
    foreach (bad[i])
    begin
      cmd(bad[i], 16'h0000);
      check(bad_command_flag, 1);
      pulse(0);
      check(bad_command_flag, 0);
    end
    ready_irq_en = 0;
    cmd(8'h01, 16'h0000, 8'h5A);
    check({bad_command_flag, ready_irq}, 2'b10);
    pulse(0);
    $display("Command code test done");
  endtask
  task automatic t_prog;
    cmd(8'h03, 16'd5);
    lwr(5, 0, 32'h1234_5678);
    lwr(5, 1, 32'hA5A5_0F0F);
    cmd(8'h01, 16'd5);
    check(u_model.peek(5, 0), 32'h1234_5678);
    check(u_model.peek(5, 1), 32'hA5A5_0F0F);
    check(u_model.peek(5, 2), 32'hFFFF_FFFF);
    lwr(5, 0, 32'h0F0F_F0F0);
    cmd(8'h01, 16'd5);
    check(u_model.peek(5, 0), 32'h0204_5070);
    lwr(5, 1, 32'hFFFF_00FF);
    cmd(8'h03, 16'd5);
    check(u_model.peek(5, 0), 32'hFFFF_FFFF);
    check(u_model.peek(5, 1), 32'hFFFF_00FF);
    $display("Program test done");
  endtask
  task automatic t_lock;
    cmd(8'h08, 16'd40);
    check(lock_bits, 64'h0000_0000_0000_0002);
    lwr(40, 0, 32'h0000_0000);
    cmd(8'h01, 16'd40);
    check({locked_region_error_flag, u_model.peek(40, 0)}, 33'h1_FFFF_FFFF);
    pulse(0);
    check(locked_region_error_flag, 0);
    cmd(8'h07, 16'd160);
    check(locked_region_error_flag, 1);
    pulse(0);
    cmd(8'h0A, 16'h0000);
    check(result_value_field, 32'h0000_0002);
    pulse(1);
    check(result_value_field, 32'h0000_0000);
    cmd(8'h09, 16'd40);
    check(lock_bits, 64'h0000_0000_0000_0000);
    cmd(8'h04, 16'd40);
    check(lock_bits, 64'h0000_0000_0000_0002);
    cmd(8'h09, 16'd40);
    $display("Lock test done");
  endtask
  task automatic t_misc;
    cmd(8'h0E, 16'h0000, 8'hA5, 0);
    repeat (6) @(negedge mclk);
    check({op_done_flag, id_read_mode}, 2'b01);
    cmd(8'h0F, 16'h0000);
    check(id_read_mode, 0);
    slow = 1;
    fail_next = 1;
    lwr(6, 0, 32'h0000_0000);
    cmd(8'h01, 16'd6);
    check(flash_error_flag, 1);
    slow = 0;
    fail_next = 0;
    pulse(0);
    check(flash_error_flag, 0);
    cmd(8'h0B, 16'd3);
    cmd(8'h0D, 16'h0000);
    check({nv_bits, result_value_field}, 40'h08_0000_0008);
    cmd(8'h14, 16'h0000);
    check(sig_read_mode, 1);
    cmd(8'h15, 16'h0000);
    check(sig_read_mode, 0);
    $display("Id mode and verify test done");
  endtask
  // ==========================================================
  // Clock, sequence and watchdog
  initial
  begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    rst_b = 0;
    {cmd_wr, status_rd, result_rd, ready_irq_en, latch_wr, slow, fail_next} = '0;
    fws = 4'h1;
    latch_addr = 20'h0_0000;
    cmd_data = 32'h0000_0000;
    latch_data = 32'h0000_0000;
    repeat (3) @(negedge mclk);
    rst_b = 1;
    t_desc;
    t_codes;
    t_prog;
    t_lock;
    t_misc;
    test_done;
  end
  initial
  begin
    #2000000;
    error_cnt++;
    test_done;
  end
endmodule
